// *** ctl_consts.vh ***
`ifndef CTL_CONSTS_VH
`define CTL_CONSTS_VH

// ----------------------------------------
// clock and sample timer
// ----------------------------------------
`define CTL_CLK_HZ 20000000
`define CTL_SCK_HZ 95000
`define CTL_SCK_HALF (`CTL_CLK_HZ / `CTL_SCK_HZ / 2)
`define CTL_MS_PER_S 1000
`define CTL_MS_CYC (`CTL_CLK_HZ / `CTL_MS_PER_S)
`define CTL_PERIOD_MS 1380
`define CTL_GATE_MS 33
`define CTL_PRELOAD_MS 11
`define CTL_CONVERT_MS 22
`define CTL_DETECT_MS 60
`define CTL_HOLD_SHORT_S 177
`define CTL_HOLD_LONG_S 708
`define CTL_MIN_MS 60000

// ----------------------------------------
// ratchet counter
// ----------------------------------------
`define CTL_CNT_W 10
`define CTL_CNT_MAX 10'h3FF
`define CTL_DROP_CNT 10'h002

// ----------------------------------------
// backup timer limits, minutes, by {lower,middle,upper}
// ----------------------------------------
`define CTL_T_111 283
`define CTL_T_110 247
`define CTL_T_101 212
`define CTL_T_100 177
`define CTL_T_011 141
`define CTL_T_010 106
`define CTL_T_001 71

// ----------------------------------------
// register map
// ----------------------------------------
`define CTL_REG_CTRL 8'h00
`define CTL_REG_STATUS 8'h04
`define CTL_REG_COUNT 8'h08
`define CTL_CTRL_RESET 32'h0000_0001
`define CTL_CTRL_DET_EN 0
`define CTL_ST_FAST 0
`define CTL_ST_GATE 1
`define CTL_ST_PRELOAD 2
`define CTL_ST_CONVERT 3
`define CTL_ST_VBAD 4
`define CTL_ST_FALL 5
`define CTL_ST_TERM 6
`define CTL_ST_OTEMP 7
`define CTL_ST_COLD 8
`define CTL_ST_TEXP 9
`define CTL_ST_TMODE 10
`define CTL_ST_DETON 11
`define CTL_ST_HOLDOK 12
`define CTL_ST_BELOW 13
`define CTL_RESP_OKAY 2'b00
`define CTL_RESP_SLVERR 2'b10

`endif

// *** ctl_core.v ***
`timescale 1ns/100ps
`default_nettype none
`include "ctl_consts.vh"

module ctl_core #(
	parameter MS_CYC = `CTL_MS_CYC,
	parameter PERIOD_MS = `CTL_PERIOD_MS,
	parameter LONG_HOLDOFF = 0,
	parameter HOLD_MS_SHORT = `CTL_HOLD_SHORT_S * `CTL_MS_PER_S,
	parameter HOLD_MS_LONG = `CTL_HOLD_LONG_S * `CTL_MS_PER_S,
	parameter MIN_MS = `CTL_MIN_MS
) (
	// clock, reset, enable
	input wire clk,
	input wire rst_b,
	input wire ce,
	// comparator flags and program inputs, asynchronous
	input wire sense_over,
	input wire sense_under,
	input wire temp_hot,
	input wire temp_cold,
	input wire program_input_upper,
	input wire program_input_middle,
	input wire program_input_lower,
	// voltage_to_pulse_converter
	output reg converter_sck,
	input wire converter_pulse,
	// open-collector drives
	output wire sample_gate_output_out,
	output wire sample_gate_output_oe,
	output wire charge_rate_out,
	output wire charge_rate_oe,
	// axi4-lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	localparam HOLD_MS = LONG_HOLDOFF ? HOLD_MS_LONG : HOLD_MS_SHORT;
	localparam NSYNC = 8;
	localparam [31:0] PH_LAST = PERIOD_MS - 1;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	wire [NSYNC-1:0] async_in;
	reg [NSYNC-1:0] sync_a;
	reg [NSYNC-1:0] sync_b;
	reg pulse_d;
	assign async_in = {converter_pulse, program_input_lower,
		program_input_middle, program_input_upper, temp_cold, temp_hot,
		sense_under, sense_over};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			always @(posedge clk) begin
				if (!rst_b) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end else if (ce) begin
					sync_a[gi] <= async_in[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	wire v_over = sync_b[0];
	wire v_under = sync_b[1];
	wire t_hot = sync_b[2];
	wire t_cold = sync_b[3];
	wire [2:0] prog = {sync_b[6], sync_b[5], sync_b[4]};
	wire v_bad = v_over | v_under;
	wire timer_mode = |prog;
	wire pulse_edge = sync_b[7] & ~pulse_d;

	// ----------------------------------------
	// registers visible to software
	// ----------------------------------------
	reg [31:0] ctrl;
	wire det_allowed = ctrl[`CTL_CTRL_DET_EN];

	// ----------------------------------------
	// converter clock and ms timebase
	// ----------------------------------------
	reg [7:0] sck_cnt;
	reg [31:0] ms_cnt;
	wire ms_tick = (ms_cnt == MS_CYC - 1);

	always @(posedge clk) begin
		if (!rst_b) begin
			sck_cnt <= 8'h00;
			converter_sck <= 1'b0;
			ms_cnt <= 32'h0000_0000;
			pulse_d <= 1'b0;
		end else if (ce) begin
			pulse_d <= sync_b[7];
			if (sck_cnt == `CTL_SCK_HALF - 1) begin
				sck_cnt <= 8'h00;
				converter_sck <= ~converter_sck;
			end else begin
				sck_cnt <= sck_cnt + 8'h01;
			end
			if (ms_tick)
				ms_cnt <= 32'h0000_0000;
			else
				ms_cnt <= ms_cnt + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// sample timer phases
	// ----------------------------------------
	reg [15:0] ph_ms;
	wire gate = (ph_ms < `CTL_GATE_MS);
	wire preload = (ph_ms < `CTL_PRELOAD_MS);
	wire convert = gate & ~preload;
	wire start_tick = ms_tick & (ph_ms == PERIOD_MS - 1);
	wire eval_tick = ms_tick & (ph_ms == `CTL_GATE_MS - 1);

	always @(posedge clk) begin
		if (!rst_b)
			ph_ms <= PH_LAST[15:0];
		else if (ce && ms_tick) begin
			if (ph_ms == PERIOD_MS - 1)
				ph_ms <= 16'h0000;
			else
				ph_ms <= ph_ms + 16'h0001;
		end
	end

	// ----------------------------------------
	// mode state
	// ----------------------------------------
	reg v_bad_d;
	reg ot_latch;
	reg term;
	reg t_expired;
	reg [31:0] fast_ms;
	reg [31:0] timer_ms;
	reg [31:0] limit_ms;
	wire v_enter = v_bad_d & ~v_bad;
	wire cold_hold = ~timer_mode & t_cold;
	wire fast = ~v_bad & ~term & ~ot_latch & ~cold_hold & ~t_expired;
	wire det_on = fast & det_allowed & (fast_ms >= `CTL_DETECT_MS);
	wire hold_ok = fast & (fast_ms >= HOLD_MS);

	always @* begin
		case (prog)
		3'b111: limit_ms = `CTL_T_111 * MIN_MS;
		3'b110: limit_ms = `CTL_T_110 * MIN_MS;
		3'b101: limit_ms = `CTL_T_101 * MIN_MS;
		3'b100: limit_ms = `CTL_T_100 * MIN_MS;
		3'b011: limit_ms = `CTL_T_011 * MIN_MS;
		3'b010: limit_ms = `CTL_T_010 * MIN_MS;
		3'b001: limit_ms = `CTL_T_001 * MIN_MS;
		default: limit_ms = 32'hFFFF_FFFF;
		endcase
	end

	// ----------------------------------------
	// ratchet counter
	// ----------------------------------------
	reg [`CTL_CNT_W-1:0] peak;
	reg [`CTL_CNT_W-1:0] ratchet;
	reg [`CTL_CNT_W-1:0] sample;
	reg below;
	reg falling;
	wire [`CTL_CNT_W:0] sample_ext = {1'b0, sample};
	wire [`CTL_CNT_W:0] lim_ext = {1'b0, ratchet};
	wire is_drop = (sample_ext + {1'b0, `CTL_DROP_CNT}) <= lim_ext;

	always @(posedge clk) begin
		if (!rst_b) begin
			v_bad_d <= 1'b0;
			ot_latch <= 1'b0;
			term <= 1'b0;
			t_expired <= 1'b0;
			fast_ms <= 32'h0000_0000;
			timer_ms <= 32'h0000_0000;
			peak <= {`CTL_CNT_W{1'b0}};
			ratchet <= {`CTL_CNT_W{1'b0}};
			sample <= {`CTL_CNT_W{1'b0}};
			below <= 1'b0;
			falling <= 1'b0;
		end else if (ce) begin
			v_bad_d <= v_bad;
			// over-temperature sets and holds
			if (~timer_mode & t_hot)
				ot_latch <= 1'b1;
			else if (v_enter)
				ot_latch <= 1'b0;
			// backup timer runs while charging fast
			if (v_enter) begin
				timer_ms <= 32'h0000_0000;
				t_expired <= 1'b0;
			end else if (timer_mode & fast & ms_tick) begin
				timer_ms <= timer_ms + 32'h0000_0001;
				if (timer_ms + 32'h0000_0001 >= limit_ms)
					t_expired <= 1'b1;
			end
			// time spent in fast mode
			if (~fast)
				fast_ms <= 32'h0000_0000;
			else if (ms_tick && fast_ms != 32'hFFFF_FFFF)
				fast_ms <= fast_ms + 32'h0000_0001;
			// termination latch
			if (v_enter)
				term <= 1'b0;
			else if (falling & hold_ok)
				term <= 1'b1;
			// preload and conversion
			if (start_tick) begin
				ratchet <= peak;
				sample <= {`CTL_CNT_W{1'b0}};
			end else if (convert && pulse_edge &&
				sample != `CTL_CNT_MAX) begin
				sample <= sample + {{(`CTL_CNT_W-1){1'b0}}, 1'b1};
			end
			if (~det_on) begin
				peak <= {`CTL_CNT_W{1'b0}};
				below <= 1'b0;
				falling <= 1'b0;
			end else if (eval_tick) begin
				if (sample > ratchet) begin
					peak <= sample;
					below <= 1'b0;
					falling <= 1'b0;
				end else if (is_drop) begin
					below <= 1'b1;
					if (below)
						falling <= 1'b1;
				end else begin
					below <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// open-collector outputs
	// ----------------------------------------
	assign sample_gate_output_out = 1'b0;
	assign sample_gate_output_oe = gate;
	assign charge_rate_out = 1'b0;
	assign charge_rate_oe = ~fast;

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	reg aw_got;
	reg w_got;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire [31:0] status;
	wire [7:0] wr_addr = s_axi_awvalid & ~aw_got ? s_axi_awaddr : aw_addr;
	wire [31:0] wr_data = s_axi_wvalid & ~w_got ? s_axi_wdata : w_data;
	wire [3:0] wr_strb = s_axi_wvalid & ~w_got ? s_axi_wstrb : w_strb;
	wire aw_ok = aw_got | (s_axi_awvalid & s_axi_awready);
	wire w_ok = w_got | (s_axi_wvalid & s_axi_wready);
	wire do_wr = ce & aw_ok & w_ok & ~s_axi_bvalid;
	wire do_rd = ce & s_axi_arvalid & s_axi_arready;

	assign s_axi_awready = ce & ~aw_got & ~s_axi_bvalid;
	assign s_axi_wready = ce & ~w_got & ~s_axi_bvalid;
	assign s_axi_arready = ce & ~s_axi_rvalid;

	assign status = {18'h0_0000, below, hold_ok, det_on, timer_mode,
		t_expired, cold_hold, ot_latch, term, falling, v_bad, convert,
		preload, gate, fast};

	integer bi;
	always @(posedge clk) begin
		if (!rst_b) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			ctrl <= `CTL_CTRL_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CTL_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `CTL_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else if (ce) begin
			if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (do_wr) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wr_addr == `CTL_REG_CTRL) begin
					s_axi_bresp <= `CTL_RESP_OKAY;
					for (bi = 0; bi < 4; bi = bi + 1)
						if (wr_strb[bi])
							ctrl[bi*8 +: 8] <= wr_data[bi*8 +: 8];
				end else if (wr_addr == `CTL_REG_STATUS ||
					wr_addr == `CTL_REG_COUNT) begin
					s_axi_bresp <= `CTL_RESP_OKAY;
				end else begin
					s_axi_bresp <= `CTL_RESP_SLVERR;
				end
			end else begin
				if (s_axi_awvalid & s_axi_awready) begin
					aw_got <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (s_axi_wvalid & s_axi_wready) begin
					w_got <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
			end
			if (do_rd) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `CTL_RESP_OKAY;
				case (s_axi_araddr)
				`CTL_REG_CTRL: s_axi_rdata <= ctrl;
				`CTL_REG_STATUS: s_axi_rdata <= status;
				`CTL_REG_COUNT: s_axi_rdata <= {6'h00, sample,
					6'h00, peak};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `CTL_RESP_SLVERR;
				end
				endcase
			end
		end
	end

endmodule // ctl_core
`default_nettype wire

// *** ctl_regulator.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// charge regulator and converter stand-in
// ----------------------------------------
module ctl_regulator (
	// clock
	input wire logic clk,
	// clocks per converter pulse, zero for none
	input wire logic [7:0] pulse_period,
	// open-collector drives of the controller
	input wire logic gate_out,
	input wire logic gate_oe,
	input wire logic rate_out,
	input wire logic rate_oe,
	// converter pulses and pulled-up pin levels
	output logic converter_pulse,
	output logic gate_pin,
	output logic rate_pin
);
	logic [7:0] cnt = 8'h00;
	assign gate_pin = gate_oe ? gate_out : 1'b1;
	assign rate_pin = rate_oe ? rate_out : 1'b1;
	always @(posedge clk) begin
		cnt <= (cnt + 8'h01 >= pulse_period) ? 8'h00 : cnt + 8'h01;
	end
	// pulse rate stands for the sensed voltage
	assign converter_pulse = (pulse_period != 8'h00) && (cnt < 8'h02);
endmodule // ctl_regulator
`default_nettype wire

// *** ctl_core_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ctl_consts.vh"
module ctl_chk #(
	parameter MS_CYC = 20,
	parameter PERIOD_MS = 40
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// sensing and pins
	input wire logic sense_over,
	input wire logic converter_sck,
	input wire logic sample_gate_output_out,
	input wire logic sample_gate_output_oe,
	input wire logic charge_rate_out,
	input wire logic charge_rate_oe,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	int gc, pc, sc;
	logic gq, sq, pseen, sseen;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// cycles in gate, since gate rise, since sck edge
	always @(posedge clk) begin
		if (!rst_b) begin
			gc <= 0;
			pc <= 0;
			sc <= 0;
			gq <= 1'b0;
			sq <= 1'b0;
			pseen <= 1'b0;
			sseen <= 1'b0;
		end else begin
			gq <= sample_gate_output_oe;
			sq <= converter_sck;
			gc <= sample_gate_output_oe ? gc + 1 : 0;
			pc <= (sample_gate_output_oe && !gq) ? 1 : pc + 1;
			pseen <= pseen || (sample_gate_output_oe && !gq);
			sc <= (converter_sck != sq) ? 1 : sc + 1;
			sseen <= sseen || (converter_sck != sq);
		end
	end
	a_gate_len: assert property ($fell(sample_gate_output_oe) |->
		gc == `CTL_GATE_MS * MS_CYC) else $error("gate length wrong");
	a_gate_period: assert property (sample_gate_output_oe && !gq &&
		pseen |-> pc == PERIOD_MS * MS_CYC) else $error("gate period wrong");
	a_sck_half: assert property (converter_sck != sq && sseen |->
		sc == `CTL_SCK_HALF) else $error("sck half period wrong");
	a_oc_low: assert property (!sample_gate_output_out &&
		!charge_rate_out) else $error("open collector drives high");
	a_over_trickle: assert property (sense_over [*5] |->
		charge_rate_oe) else $error("no trickle on overvoltage");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read response late");
	a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready &&
		!s_axi_wready) else $error("write taken while busy");
	a_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
endmodule // ctl_chk
bind ctl_core ctl_chk #(.MS_CYC(MS_CYC), .PERIOD_MS(PERIOD_MS)) i_ctl_chk (
	.clk(clk), .rst_b(rst_b), .sense_over(sense_over),
	.converter_sck(converter_sck),
	.sample_gate_output_out(sample_gate_output_out),
	.sample_gate_output_oe(sample_gate_output_oe),
	.charge_rate_out(charge_rate_out), .charge_rate_oe(charge_rate_oe),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ctl_consts.vh"
module tb_top;
	localparam int MS = 40;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic sense_over = 1'b0;
	logic sense_under = 1'b0;
	logic temp_hot = 1'b0;
	logic temp_cold = 1'b0;
	logic [2:0] prog = 3'h0;
	logic [7:0] pulse_period = 8'h08;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic sck, pulse, g_out, g_oe, r_out, r_oe, g_pin, r_pin;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	logic [31:0] d;
	logic [1:0] r;
	int errors = 0;
	int tests_run = 0;
	ctl_core #(.MS_CYC(MS), .PERIOD_MS(40), .HOLD_MS_SHORT(300), .MIN_MS(5))
	i_ctl_core (
	.clk(clk), .rst_b(rst_b), .ce(1'b1), .sense_over(sense_over),
	.sense_under(sense_under), .temp_hot(temp_hot), .temp_cold(temp_cold),
	.program_input_upper(prog[0]), .program_input_middle(prog[1]),
	.program_input_lower(prog[2]), .converter_sck(sck),
	.converter_pulse(pulse), .sample_gate_output_out(g_out),
	.sample_gate_output_oe(g_oe), .charge_rate_out(r_out),
	.charge_rate_oe(r_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
	.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
	.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
	.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
	.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
	.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ctl_regulator i_ctl_regulator (.clk(clk), .pulse_period(pulse_period),
	.gate_out(g_out), .gate_oe(g_oe), .rate_out(r_out), .rate_oe(r_oe),
	.converter_pulse(pulse), .gate_pin(g_pin), .rate_pin(r_pin));
	initial begin
		forever #25 clk = ~clk;
	end
	task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task end_sim;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task do_reset;
		rst_b <= 1'b0;
		cyc(6);
		rst_b <= 1'b1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		cmp(bresp, e, "write response");
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task st(input int b, input logic v);
		rd(`CTL_REG_STATUS);
		cmp(d[b], v, "status bit");
	endtask
	task falls(input int k);
		repeat (k) begin
			do @(posedge clk); while (!g_oe);
			do @(posedge clk); while (g_oe);
		end
	endtask
	// ----------------------------------------
	// peak tracking, falling slope, holdoff
	// ----------------------------------------
	task slope(input logic rec);
		do_reset;
		pulse_period <= 8'h08;
		cyc(1);
		cmp(r_oe, 0, "after reset");
		falls(3);
		rd(`CTL_REG_COUNT);
		cmp(d[9:0] >= 109 && d[9:0] <= 111, 1, "peak");
		pulse_period <= 8'h0a;
		falls(1);
		st(`CTL_ST_BELOW, 1);
		falls(1);
		st(`CTL_ST_FALL, 1);
		cmp(r_oe, 0, "holdoff");
		if (rec) pulse_period <= 8'h06;
		falls(5);
		st(`CTL_ST_HOLDOK, rec);
		st(`CTL_ST_TERM, !rec);
		cmp(r_oe, !rec, "termination");
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		end_sim;
	end
	initial begin
		do_reset;
		cyc(1);
		cmp(r_pin, 1, "rate released");
		st(`CTL_ST_FAST, 1);
		rd(`CTL_REG_CTRL);
		cmp(d, `CTL_CTRL_RESET, "ctrl reset");
		rd(8'h40);
		cmp(r, `CTL_RESP_SLVERR, "unmapped read resp");
		cmp(d, 32'h0000_0000, "unmapped read data");
		wr(8'h40, 32'h0000_0001, `CTL_RESP_SLVERR);
		wr(`CTL_REG_STATUS, 32'hffff_ffff, `CTL_RESP_OKAY);
		wr(`CTL_REG_CTRL, 32'h0000_0000, `CTL_RESP_OKAY);
		rd(`CTL_REG_CTRL);
		cmp(d, 32'h0000_0000, "ctrl write");
		wr(`CTL_REG_CTRL, `CTL_CTRL_RESET, `CTL_RESP_OKAY);
		do @(posedge clk); while (!g_oe);
		cmp(g_pin, 0, "gate pin");
		rd(`CTL_REG_STATUS);
		cmp(d[3:1], 3'b011, "preload");
		cyc(12 * MS);
		rd(`CTL_REG_STATUS);
		cmp(d[3:1], 3'b101, "convert");
		slope(1'b0);
		sense_under <= 1'b1;
		cyc(5);
		cmp(r_oe, 1, "under");
		sense_under <= 1'b0;
		cyc(5);
		cmp(r_oe, 0, "window");
		st(`CTL_ST_TERM, 0);
		temp_cold <= 1'b1;
		cyc(5);
		cmp(r_oe, 1, "cold");
		temp_cold <= 1'b0;
		cyc(5);
		cmp(r_oe, 0, "cold back");
		temp_hot <= 1'b1;
		cyc(5);
		cmp(r_oe, 1, "hot");
		temp_hot <= 1'b0;
		cyc(5);
		cmp(r_oe, 1, "hot latch");
		sense_over <= 1'b1;
		cyc(5);
		sense_over <= 1'b0;
		cyc(5);
		cmp(r_oe, 0, "over back");
		temp_hot <= 1'b1;
		cyc(5);
		temp_hot <= 1'b0;
		slope(1'b1);
		st(`CTL_ST_TMODE, 0);
		for (int i = 1; i < 8; i++) begin
			prog <= i[2:0];
			cyc(5);
			st(`CTL_ST_TMODE, 1);
		end
		prog <= 3'b001;
		do_reset;
		cyc((71 * 5 - 5) * MS);
		cmp(r_oe, 0, "timer run");
		cyc(10 * MS);
		cmp(r_oe, 1, "timer end");
		st(`CTL_ST_TEXP, 1);
		end_sim;
	end
endmodule // tb_top
`default_nettype wire
